// ==== hdl/obd_option_decoder.sv ====
// option byte store, programmer view, reset latch and clock settle wait
`default_nettype none
module obd_option_decoder
  import obd_pkg::*;
#(
  parameter int STAB_CYCLES = OBD_STAB_CYC
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic progMode,
  input wire logic [14:0] progAddr,
  input wire logic [7:0] progDataIn,
  input wire logic progWrite,
  input wire logic progRead,
  output logic [7:0] progDataOut,
  input wire logic [15:0] cpuAddr,
  output logic [7:0] cpuData,
  input wire logic stopReq,
  input wire logic wakeReq,
  output logic running,
  output obd_opts_t opts
);
  // ----------------------------------------
  // parameter checks
  // ----------------------------------------
  // the settle counter needs at least one cycle to count
  if (STAB_CYCLES < 1) begin : gBadStab
    $error("STAB_CYCLES must be at least 1");
  end

  // ----------------------------------------
  // array storage
  // ----------------------------------------
  // otp model: programming only clears bits, erased state is all ones
  logic [7:0] rom [0:32767] = '{default: OBD_ERASED}; // R6
  logic pmA;
  logic pmB;
  logic wrA;
  logic wrB;
  logic wrPrev;
  logic rdA;
  logic rdB;
  logic [14:0] addrA;
  logic [14:0] addrB;
  logic [7:0] dinA;
  logic [7:0] dinB;
  logic writeEdge;
  logic readEn;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  // pins come from the programmer socket, so each passes two flops
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pmA <= 1'b0;
      pmB <= 1'b0;
    end else begin
      pmA <= progMode;
      pmB <= pmA;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wrA <= 1'b0;
      wrB <= 1'b0;
      wrPrev <= 1'b0;
    end else begin
      wrA <= progWrite;
      wrB <= wrA;
      wrPrev <= wrB;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdA <= 1'b0;
      rdB <= 1'b0;
    end else begin
      rdA <= progRead;
      rdB <= rdA;
    end
  end

  // words are only used while held steady around a strobe
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      addrA <= 15'h0000;
      addrB <= 15'h0000;
    end else begin
      addrA <= progAddr;
      addrB <= addrA;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dinA <= 8'h00;
      dinB <= 8'h00;
    end else begin
      dinA <= progDataIn;
      dinB <= dinA;
    end
  end

  assign writeEdge = pmB && wrB && !wrPrev;
  assign readEn = pmB && rdB;

  // ----------------------------------------
  // programming
  // ----------------------------------------
  // a cell can only lose ones, one program pulse per strobe edge
  always_ff @(posedge mclk) begin
    if (writeEdge) begin
      rom[addrB] <= rom[addrB] & dinB; // R2
    end
  end

  // read: vacant bits read as stored, so erased ones stay one; no signature mode
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      progDataOut <= OBD_ERASED;
    end else if (readEn) begin
      progDataOut <= rom[addrB]; // R1 R2 R7 R9
    end
  end

  // ----------------------------------------
  // cpu view
  // ----------------------------------------
  // cpu view: single-chip 8006-FFFF is programmer 0006-7FFF
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cpuData <= 8'hFF;
    end else if (cpuAddr >= OBD_PROG_BASE) begin
      cpuData <= rom[cpuAddr[14:0]]; // R1
    end else begin
      cpuData <= 8'hFF;
    end
  end

  // ----------------------------------------
  // reset latch and settle
  // ----------------------------------------
  obd_state_t state;
  logic [$clog2(STAB_CYCLES+1)-1:0] stabCnt;
  logic [2:0] loadIdx;
  logic [7:0] optCopy [0:OBD_NUM_OPT-1];

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= OBD_LOAD;
      loadIdx <= 3'h0;
      stabCnt <= '0;
    end else begin
      case (state)
        OBD_LOAD: begin
          if (loadIdx == 3'(OBD_NUM_OPT - 1)) state <= OBD_SETTLE;
          loadIdx <= loadIdx + 3'h1;
          stabCnt <= '0;
        end
        OBD_SETTLE: begin
          if (stabCnt == $bits(stabCnt)'(STAB_CYCLES - 1)) state <= OBD_RUN; // R10
          stabCnt <= stabCnt + 1'b1;
        end
        OBD_RUN: if (stopReq) state <= OBD_STOP;
        OBD_STOP: begin
          stabCnt <= '0;
          if (wakeReq) state <= OBD_SETTLE; // R10
        end
        default: state <= OBD_LOAD;
      endcase
    end
  end

  // ----------------------------------------
  // option copy
  // ----------------------------------------
  // copy taken once after reset release, then held
  generate
    for (genvar g = 0; g < OBD_NUM_OPT; g++) begin : gCopy
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) optCopy[g] <= OBD_ERASED; // R6
        else if (state == OBD_LOAD && loadIdx == 3'(g))
          optCopy[g] <= rom[g]; // R11
      end
    end
  endgenerate

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign running = (state == OBD_RUN);

  // pull-up enable is the inverse of the stored bit
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      opts.dualClock <= 1'b1; // R6
      opts.com3PullEn <= 1'b0;
      opts.port0PullEn <= 8'h00;
      opts.port3PullEn <= 8'h00;
      opts.port6PullEn <= 8'h00;
      opts.port4to2PullEn <= 8'h00;
      opts.port1PullEn <= 5'h00;
    end else begin
      opts.dualClock <= optCopy[0][OBD_CLK_BIT]; // R4 R11
      opts.com3PullEn <= ~optCopy[0][OBD_COM3_BIT]; // R3 R5
      opts.port0PullEn <= ~optCopy[1]; // R3
      opts.port3PullEn <= ~optCopy[2]; // R3
      opts.port6PullEn <= ~optCopy[3]; // R3
      opts.port4to2PullEn <= ~optCopy[4]; // R3
      opts.port1PullEn <= ~optCopy[5][4:0]; // R3
    end
  end
endmodule : obd_option_decoder
`default_nettype wire

// ==== hdl/obd_pkg.sv ====
// package for the one-time option byte decoder
//
// Behaviour
// [R1] programmer 0006-7FFF maps single-chip 8006-FFFF
// [R2] option bytes sit at programmer 0000-0005
// [R3] pull-up bit 1 disables, 0 enables
// [R4] byte0 bit0: 1 dual clock, 0 single
// [R5] byte0 bit2 drives common-3 shared pin pull-up
// [R6] erased cells read 1: no pull-ups, dual
// [R7] vacant bits read 1 unless programmed 0
// [R8] programmer never programs vacant bits to 0
// [R9] no electronic signature answer in programming mode
// [R10] wait oscillation settle after reset and stop
// [R11] latch options at reset, drive from copy
`default_nettype none
package obd_pkg;
  localparam int OBD_NUM_OPT = 6;
  localparam logic [14:0] OBD_OPT_LAST = 15'h0005;
  localparam logic [15:0] OBD_PROG_BASE = 16'h8000;
  localparam logic [7:0] OBD_ERASED = 8'hFF;
  localparam logic [7:0] OBD_VACANT0 = 8'hF8;
  localparam logic [7:0] OBD_VACANT5 = 8'hE0;
  localparam int OBD_CLK_BIT = 0;
  localparam int OBD_COM3_BIT = 2;
  localparam int OBD_STAB_US = 4000;
  localparam int OBD_MCLK_MHZ = 125;
  localparam int OBD_STAB_CYC = OBD_STAB_US * OBD_MCLK_MHZ;

  typedef enum logic [1:0] {
    OBD_LOAD = 2'b00,
    OBD_SETTLE = 2'b01,
    OBD_RUN = 2'b11,
    OBD_STOP = 2'b10
  } obd_state_t;

  typedef struct packed {
    logic dualClock;
    logic com3PullEn;
    logic [7:0] port0PullEn;
    logic [7:0] port3PullEn;
    logic [7:0] port6PullEn;
    logic [7:0] port4to2PullEn;
    logic [4:0] port1PullEn;
  } obd_opts_t;
endpackage : obd_pkg
`default_nettype wire

// ==== test/obd_option_decoder_test.sv ====
// self-checking bench for the option byte decoder
`default_nettype none
module obd_option_decoder_test;
  import obd_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0, rst_n = 1'b0, stopReq = 1'b0, wakeReq = 1'b0;
  logic progMode, progWrite, progRead, running;
  logic [15:0] cpuAddr = 16'h7FFF;
  logic [14:0] progAddr;
  logic [7:0] progDataIn, progDataOut, cpuData;
  logic [6:0][7:0] opt = 56'h00;
  obd_opts_t opts;
  int errors = 0, comparisons = 0, cycles = 0, seed = 32'h4C21;
  obd_prog u_prog (.clk(mclk), .mode(progMode), .addr(progAddr), .data(progDataIn),
    .wr(progWrite), .rd(progRead));
  localparam int stabCycles = 20;
  obd_option_decoder #(.STAB_CYCLES(stabCycles)) u_dut (.mclk, .rst_n, .progMode, .progAddr,
    .progDataIn, .progWrite, .progRead, .progDataOut, .cpuAddr, .cpuData, .stopReq,
    .wakeReq, .running, .opts);
  function automatic obd_opts_t expOpts(input logic [6:0][7:0] b);
    return '{b[0][0], ~b[0][2], ~b[1], ~b[2], ~b[3], ~b[4], ~b[5][4:0]};
  endfunction : expOpts
  // stored byte: vacant bits were written as ones by the programmer
  function automatic logic [7:0] expRead(input int idx);
    return opt[idx] | (idx == 0 ? OBD_VACANT0 : idx == 5 ? OBD_VACANT5 : 8'h00);
  endfunction : expRead
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %0t %0h %0h", $time, seen, exp);
    end
  endtask : check
  task automatic end_sim();
    if (errors == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_sim
  // options only reach the pads through a reset
  task automatic doReset();
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (40) @(negedge mclk);
  endtask : doReset
  initial forever #4 mclk = ~mclk;
  always @(posedge mclk)
    if (++cycles == 1000) begin
      errors++;
      end_sim();
    end
  initial begin
    doReset();
    check(64'(opts), 64'(expOpts('1)));
    check(64'(cpuData), 64'hFF);
    for (int i = 0; i < 7; i++) begin
      if (i > 0) opt[i] = 8'($random(seed));
      u_prog.xfer(15'(i), opt[i], 1'b1);
    end
    check(64'(opts), 64'(expOpts('1)));
    @(posedge mclk);
    cpuAddr <= 16'h8006;
    for (int i = 0; i < 7; i++) begin
      u_prog.xfer(15'(i), 8'h00, 1'b0);
      check(64'(progDataOut), 64'(expRead(i)));
    end
    check(64'(cpuData), 64'(opt[6]));
    doReset();
    check(64'(opts), 64'(expOpts(opt)));
    check(64'(running), 64'h1);
    @(posedge mclk);
    stopReq <= 1'b1;
    @(posedge mclk);
    {stopReq, wakeReq} <= 2'b01;
    @(negedge mclk);
    check(64'(running), 64'h0);
    @(posedge mclk);
    wakeReq <= 1'b0;
    repeat (stabCycles) @(negedge mclk);
    check(64'(running), 64'h0);
    @(negedge mclk);
    check(64'(running), 64'h1);
    end_sim();
  end
endmodule : obd_option_decoder_test
`default_nettype wire

// ==== test/obd_prog.sv ====
// programmer model on the programming pins
`default_nettype none
module obd_prog (
  input wire logic clk,
  output logic mode = 1'b0,
  output logic [14:0] addr = 15'h0000,
  output logic [7:0] data = 8'hFF,
  output logic wr = 1'b0,
  output logic rd = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  // one byte a call; plain reads only, so no signature query
  task automatic xfer(input logic [14:0] a, input logic [7:0] d, input logic w);
    @(posedge clk);
    {mode, rd, addr} <= {1'b1, ~w, a};
    data <= d | (a == 15'h0000 ? 8'hF8 : a == 15'h0005 ? 8'hE0 : 8'h00);
    repeat (4) @(posedge clk);
    wr <= w;
    repeat (4) @(posedge clk);
    // released data lines show the inverse, not a stale byte
    {mode, wr, rd, data} <= {3'b000, ~d};
    repeat (4) @(negedge clk);
  endtask : xfer
endmodule : obd_prog
`default_nettype wire

// ==== test/obd_props.sv ====
// port checker for the option byte decoder
`default_nettype none
module obd_props
  import obd_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic progMode,
  input wire logic [14:0] progAddr,
  input wire logic progRead,
  input wire logic [7:0] progDataOut,
  input wire logic [15:0] cpuAddr,
  input wire logic [7:0] cpuData,
  input wire logic stopReq,
  input wire logic running,
  input wire obd_opts_t opts
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  a_low_read: assert property (cpuAddr < 16'h8000 |=> cpuData == 8'hFF) else $error("low");
  a_view_match: assert property ((progMode && progRead && cpuAddr == {1'b1, progAddr})[*4]
    |=> cpuData == progDataOut) else $error("view");
  a_vacant_low: assert property ((progMode && progRead && progAddr == 15'h0000)[*4]
    |=> progDataOut[7:3] == 5'h1F) else $error("vacant");
  a_vacant_high: assert property ((progMode && progRead && progAddr == 15'h0005)[*4]
    |=> progDataOut[7:5] == 3'h7) else $error("vacant");
  a_stop_now: assert property (stopReq && running |=> !running) else $error("stop");
  a_wake_wait: assert property ($fell(running) |=> (!running)[*8]) else $error("wake");
  a_boot_wait: assert property ($rose(rst_n) |-> (!running)[*8]) else $error("boot");
  a_opts_held: assert property (running |-> $stable(opts)) else $error("opts");
  cover property ($fell(running));
  cover property ($rose(running));
  cover property (progMode && progRead);
endmodule : obd_props
bind obd_option_decoder obd_props u_props (.mclk, .rst_n, .progMode, .progAddr, .progRead,
  .progDataOut, .cpuAddr, .cpuData, .stopReq, .running, .opts);
`default_nettype wire
